/* File: prm_ref_ctrl.sv */
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "prm_params.svh"
//
// Contract
// R01: Boot runs on ring oscillator; software may stop it after boot completes.
// R02: Register port works with or without the ring oscillator.
// R03: Each reference input is usable only while its enable bit is set.
// R04: Reference prescale by 1,2,4,8; crystal pin halving by 1 or 2.
// R05: Software picks dividers for a common detector rate 9.72 to 156.25 MHz.
// R06: Invert bit flips an input's polarity before use.
// R07: About four idle feedback cycles (eight doubled) clear input valid.
// R08: Valid is set only after a clean run of the qualify interval.
// R09: Status gives real-time valid and latched change bits per input.
// R10: Mux selects any reference, crystal pin or crystal driver source.
// R11: With both switch enables off the mux follows the primary select.
// R12: Pin switching: pin low selects primary, high selects alternate.
// R13: Monitor switching: primary while primary valid, else alternate.
// R14: Selected source is reported in real time.
// R15: Analog core runs only while the enable bit is one.
// R16: Feedback ratio is main plus remainder over denominator, scaled.
// R17: Main divider is 42 bits, 9 integer bits, binary point programmable.
// R18: Software should use 24 fractional bits, never fewer than 12.
// R19: Software keeps input rate times ratio within oscillator range.
// R20: Integer output divider setting, typical value six.
// R21: Software toggles enable 0 to 1 after changing feedback fields.
// R22: Lock status is reported in real time.
// R23: Doubler doubles the PLL input and raises the missing-edge threshold.
// R24: Latched status stays set until software clears it.
module prm_ref_ctrl
  import prm_pkg::*;
#(
  parameter int QBITS = 10
)(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic [2:0]  REF_CLK,
  input  wire logic        XTAL_CLK,
  input  wire logic [3:0]  GPIO,
  input  wire logic        PLL_LOCK,
  input  wire logic        BOOT_DONE,
  output logic             RING_OSC_EN,
  output logic             PLL_EN,
  output prm_src_t         REF_SEL,
  output prm_in_cfg_t      IN_CFG,
  output prm_fb_cfg_t      FB_CFG
);
  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************
  logic [9:0] s1_r, s2_r, s3_r, flt_r;
  logic [9:0] raw;
  assign raw = {BOOT_DONE, PLL_LOCK, GPIO, XTAL_CLK, REF_CLK};
  // A level is accepted only once the second and third stages agree.
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      s1_r  <= 10'h000;
      s2_r  <= 10'h000;
      s3_r  <= 10'h000;
      flt_r <= 10'h000;
    end
    else
    begin
      s1_r  <= raw;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      flt_r <= (flt_r & ~(s2_r ~^ s3_r)) | (s2_r & (s2_r ~^ s3_r));
    end
  end
  logic boot_done, lock_s;
  assign boot_done = flt_r[9];
  assign lock_s    = flt_r[8];

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  logic        pll_en_r, rosc_dis_r, pin_sw_r, mon_sw_r;
  logic [1:0]  pin_sel_r;
  prm_src_t    prim_r, alt_r;
  logic [15:0] valid_qualify_time_r;
  logic [3:0]  mck_r;
  logic [3:0]  clr;
  assign clr = (WR && ADDR == `PRM_OFS_LATCH) ? WDATA[3:0] : 4'h0;
  // Register writes; the feedback fields only take effect in the core
  // after software re-enables it, so no shadowing is done here.
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pll_en_r   <= 1'b0;
      rosc_dis_r <= 1'b0;
      pin_sw_r   <= 1'b0;
      mon_sw_r   <= 1'b0;
      pin_sel_r  <= 2'h0;
      prim_r     <= PRM_SRC_REF1;
      alt_r      <= PRM_SRC_REF1;
      valid_qualify_time_r  <= 16'h0000;
      mck_r      <= 4'h0;
      IN_CFG     <= '0;
      FB_CFG     <= '{fb_main: 42'h0, fb_rem: 32'h0, fb_den: `PRM_RST_FB_DEN,
                      fb_bp: `PRM_RST_FB_BP, vco_div: `PRM_RST_VCO_DIV};
    end
    else if (WR)
    begin
      unique case (ADDR)
        `PRM_OFS_CTRL:
        begin
          pll_en_r   <= WDATA[`PRM_CTL_PLL_EN]; // [R15] [R21]
          // The oscillator may only be stopped once boot is complete.
          rosc_dis_r <= WDATA[`PRM_CTL_ROSC_DIS] & boot_done; // [R01]
          IN_CFG.xtal_halve <= WDATA[`PRM_CTL_XHALVE]; // [R04]
          IN_CFG.doubler    <= WDATA[`PRM_CTL_DBL]; // [R23]
          pin_sw_r   <= WDATA[`PRM_CTL_PIN_SW];
          mon_sw_r   <= WDATA[`PRM_CTL_MON_SW];
          pin_sel_r  <= WDATA[`PRM_CTL_PIN_SEL +: 2];
        end
        `PRM_OFS_INCFG:
        begin
          IN_CFG.enable <= WDATA[2:0]; // [R03]
          IN_CFG.invert <= WDATA[6:4]; // [R06]
          mck_r         <= WDATA[11:8];
        end
        `PRM_OFS_PRESC:   IN_CFG.prescale <= WDATA[5:0]; // [R04]
        `PRM_OFS_MUX:
        begin
          prim_r <= prm_src_t'(WDATA[2:0]); // [R10]
          alt_r  <= prm_src_t'(WDATA[6:4]);
        end
        `PRM_OFS_VALID_QUALIFY_TIME: valid_qualify_time_r <= WDATA[15:0];
        `PRM_OFS_FBM_LO:  FB_CFG.fb_main[31:0]  <= WDATA; // [R17]
        `PRM_OFS_FBM_HI:  FB_CFG.fb_main[41:32] <= WDATA[9:0]; // [R17]
        `PRM_OFS_FB_REM:  FB_CFG.fb_rem <= WDATA; // [R16]
        `PRM_OFS_FB_DEN:  FB_CFG.fb_den <= WDATA; // [R16]
        `PRM_OFS_FB_BP:   FB_CFG.fb_bp  <= WDATA[5:0]; // [R16]
        `PRM_OFS_VCO_DIV: FB_CFG.vco_div <= WDATA[7:0]; // [R20]
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Activity monitors, three references plus the crystal pin.
  // ****************************************************************
  logic div2_r;
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      div2_r <= 1'b0;
    else
      div2_r <= ~div2_r;
  end
  logic [3:0] valid, valid_d_r, latch_r;
  logic [3:0] thr;
  assign thr = IN_CFG.doubler ? `PRM_MISS_DBL : `PRM_MISS_NORM; // [R23]
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_mon
      prm_mon_t         st_r;
      logic [3:0]       miss_r;
      logic [QBITS-1:0] qual_r, qlim;
      logic             prev_r, lvl, en, edge_s, tick, tmo;
      // The crystal pin has no invert or enable bit; the modulo keeps its unused index legal.
      assign en   = (gi == 3) ? 1'b1 : IN_CFG.enable[gi % 3]; // [R03]
      assign lvl  = flt_r[gi] ^ ((gi == 3) ? 1'b0 : IN_CFG.invert[gi % 3]); // [R06]
      assign edge_s = en & lvl & ~prev_r;
      // Select bit picks the full-rate or half-rate feedback tick.
      assign tick = mck_r[gi] ? div2_r : 1'b1;
      assign tmo  = !en || (miss_r >= thr); // [R07]
      assign qlim = QBITS'(({6'h00, valid_qualify_time_r[gi*4 +: 4]} + 10'h001)
                           * `PRM_QUAL_UNIT_CYC);
      assign valid[gi] = (st_r == PRM_MON_OK);
      always_ff @(posedge CLK or negedge NRST)
      begin
        if (!NRST)
        begin
          prev_r <= 1'b0;
          miss_r <= 4'h0;
        end
        else
        begin
          prev_r <= lvl;
          if (edge_s)
            miss_r <= 4'h0;
          else if (tick && miss_r < thr)
            miss_r <= miss_r + 4'h1; // [R07]
        end
      end
      // Qualification restarts on every timeout, so only a clean run counts.
      always_ff @(posedge CLK or negedge NRST)
      begin
        if (!NRST)
        begin
          st_r   <= PRM_MON_BAD;
          qual_r <= '0;
        end
        else
        begin
          unique case (st_r)
            PRM_MON_BAD:
              if (edge_s)
              begin
                st_r   <= PRM_MON_QUAL;
                qual_r <= '0;
              end
            PRM_MON_QUAL:
              if (tmo)
                st_r <= PRM_MON_BAD;
              else if (qual_r >= qlim)
                st_r <= PRM_MON_OK; // [R08]
              else
                qual_r <= qual_r + QBITS'(1);
            PRM_MON_OK:
              if (tmo)
                st_r <= PRM_MON_BAD; // [R07]
          endcase
        end
      end
      property p_mon_miss;
        @(posedge CLK) disable iff (!NRST)
        (miss_r >= thr) && !edge_s |=> !valid[gi];
      endproperty
      a_mon_miss: assert property (p_mon_miss) else $error("valid after timeout"); // [R07]
      property p_mon_qual;
        @(posedge CLK) disable iff (!NRST)
        $rose(valid[gi]) |-> $past(st_r) == PRM_MON_QUAL && $past(qual_r) >= $past(qlim);
      endproperty
      a_mon_qual: assert property (p_mon_qual) else $error("valid without qualify"); // [R08]
      property p_mon_en;
        @(posedge CLK) disable iff (!NRST)
        !en |=> !valid[gi];
      endproperty
      a_mon_en: assert property (p_mon_en) else $error("disabled input valid"); // [R03]
    end
  endgenerate

  // Latched change bits; a change in the clearing cycle keeps the bit set.
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      valid_d_r <= 4'h0;
      latch_r   <= 4'h0;
    end
    else
    begin
      valid_d_r <= valid;
      latch_r   <= (latch_r & ~clr) | (valid ^ valid_d_r); // [R09] [R24]
    end
  end

  // ****************************************************************
  // Reference selection and outputs.
  // ****************************************************************
  logic     pin_lvl, prim_ok;
  prm_src_t sel_nxt;
  logic [1:0] pmon;
  assign pin_lvl = flt_r[4 + pin_sel_r];
  // Both crystal sources share the crystal pin monitor.
  assign pmon    = (prim_r >= PRM_SRC_XPIN) ? 2'h3 : prim_r[1:0];
  assign prim_ok = valid[pmon];
  always_comb
  begin
    if (pin_sw_r)
      sel_nxt = pin_lvl ? alt_r : prim_r; // [R12]
    else if (mon_sw_r)
      sel_nxt = prim_ok ? prim_r : alt_r; // [R13]
    else
      sel_nxt = prim_r; // [R11]
  end
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      REF_SEL     <= PRM_SRC_REF1;
      PLL_EN      <= 1'b0;
      RING_OSC_EN <= 1'b1;
    end
    else
    begin
      REF_SEL     <= sel_nxt; // [R10] [R14]
      PLL_EN      <= pll_en_r; // [R15]
      RING_OSC_EN <= ~rosc_dis_r; // [R01]
    end
  end

  // ****************************************************************
  // Register read port; data stand one cycle after the strobe.
  // ****************************************************************
  // Plain synchronous port, independent of the ring oscillator.
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      RDATA <= 32'h0000_0000;
    else if (RD)
    begin
      unique case (ADDR) // [R02]
        `PRM_OFS_CTRL:    RDATA <= {24'h0, pin_sel_r, mon_sw_r, pin_sw_r,
                                    IN_CFG.doubler, IN_CFG.xtal_halve,
                                    rosc_dis_r, pll_en_r};
        `PRM_OFS_INCFG:   RDATA <= {20'h0, mck_r, 1'b0, IN_CFG.invert,
                                    1'b0, IN_CFG.enable};
        `PRM_OFS_PRESC:   RDATA <= {26'h0, IN_CFG.prescale};
        `PRM_OFS_MUX:     RDATA <= {25'h0, alt_r, 1'b0, prim_r};
        `PRM_OFS_VALID_QUALIFY_TIME: RDATA <= {16'h0, valid_qualify_time_r};
        `PRM_OFS_FBM_LO:  RDATA <= FB_CFG.fb_main[31:0];
        `PRM_OFS_FBM_HI:  RDATA <= {22'h0, FB_CFG.fb_main[41:32]};
        `PRM_OFS_FB_REM:  RDATA <= FB_CFG.fb_rem;
        `PRM_OFS_FB_DEN:  RDATA <= FB_CFG.fb_den;
        `PRM_OFS_FB_BP:   RDATA <= {26'h0, FB_CFG.fb_bp};
        `PRM_OFS_VCO_DIV: RDATA <= {24'h0, FB_CFG.vco_div};
        `PRM_OFS_STATUS:  RDATA <= {18'h0, boot_done, lock_s, 1'b0, REF_SEL,
                                    4'h0, valid}; // [R09] [R14] [R22]
        `PRM_OFS_LATCH:   RDATA <= {28'h0, latch_r};
        default:          RDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Assertions and covers.
  // ****************************************************************
  property p_rosc;
    @(posedge CLK) disable iff (!NRST)
    $fell(RING_OSC_EN) |-> $past(boot_done, 2);
  endproperty
  a_rosc: assert property (p_rosc) else $error("oscillator stopped before boot"); // [R01]
  property p_stat_rd;
    @(posedge CLK) disable iff (!NRST)
    RD && ADDR == `PRM_OFS_STATUS |=> RDATA[3:0] == $past(valid);
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status read mismatch"); // [R09]
  property p_latch;
    @(posedge CLK) disable iff (!NRST)
    (valid != valid_d_r) |=> (~latch_r & ($past(valid) ^ $past(valid_d_r))) == 4'h0;
  endproperty
  a_latch: assert property (p_latch) else $error("change not latched"); // [R24]
  property p_manual;
    @(posedge CLK) disable iff (!NRST)
    !pin_sw_r && !mon_sw_r |=> REF_SEL == $past(prim_r);
  endproperty
  a_manual: assert property (p_manual) else $error("manual select wrong"); // [R11]
  property p_pin;
    @(posedge CLK) disable iff (!NRST)
    pin_sw_r |=> REF_SEL == ($past(pin_lvl) ? $past(alt_r) : $past(prim_r));
  endproperty
  a_pin: assert property (p_pin) else $error("pin select wrong"); // [R12]
  property p_monsw;
    @(posedge CLK) disable iff (!NRST)
    !pin_sw_r && mon_sw_r && !prim_ok |=> REF_SEL == $past(alt_r);
  endproperty
  a_monsw: assert property (p_monsw) else $error("monitor switch wrong"); // [R13]
  property p_pll_en;
    @(posedge CLK) disable iff (!NRST)
    WR && ADDR == `PRM_OFS_CTRL |=> ##1 PLL_EN == $past(WDATA[0], 2);
  endproperty
  a_pll_en: assert property (p_pll_en) else $error("enable not applied"); // [R15]
  c_valid:  cover property (@(posedge CLK) disable iff (!NRST) $rose(valid[0]));
  c_failov: cover property (@(posedge CLK) disable iff (!NRST)
                            mon_sw_r && !prim_ok && REF_SEL == alt_r && alt_r != prim_r);
  c_pinsw:  cover property (@(posedge CLK) disable iff (!NRST) pin_sw_r && pin_lvl);
  c_relock: cover property (@(posedge CLK) disable iff (!NRST) $rose(PLL_EN));
endmodule // prm_ref_ctrl

/* File: prm_params.svh */
`ifndef PRM_PARAMS_SVH
`define PRM_PARAMS_SVH
// ****************************************************************
// Register offsets (byte addresses, one 32-bit word each).
// ****************************************************************
`define PRM_OFS_CTRL     8'h00
`define PRM_OFS_INCFG    8'h04
`define PRM_OFS_PRESC    8'h08
`define PRM_OFS_MUX      8'h0C
`define PRM_OFS_VALID_QUALIFY_TIME  8'h10
`define PRM_OFS_FBM_LO   8'h14
`define PRM_OFS_FBM_HI   8'h18
`define PRM_OFS_FB_REM   8'h1C
`define PRM_OFS_FB_DEN   8'h20
`define PRM_OFS_FB_BP    8'h24
`define PRM_OFS_VCO_DIV  8'h28
`define PRM_OFS_STATUS   8'h2C
`define PRM_OFS_LATCH    8'h30
// ****************************************************************
// Field positions.
// ****************************************************************
`define PRM_CTL_PLL_EN   0
`define PRM_CTL_ROSC_DIS 1
`define PRM_CTL_XHALVE   2
`define PRM_CTL_DBL      3
`define PRM_CTL_PIN_SW   4
`define PRM_CTL_MON_SW   5
`define PRM_CTL_PIN_SEL  6
`define PRM_ST_SEL       8
`define PRM_ST_LOCK      12
`define PRM_ST_BOOT      13
// ****************************************************************
// Reset values and timing.
// ****************************************************************
`define PRM_RST_VCO_DIV  8'h06
`define PRM_RST_FB_DEN   32'h0000_0001
`define PRM_RST_FB_BP    6'h09
`define PRM_MISS_NORM    4'h4
`define PRM_MISS_DBL     4'h8
`define PRM_CLK_PERIOD_NS 25
`define PRM_QUAL_UNIT_NS 1000
`define PRM_QUAL_UNIT_CYC (`PRM_QUAL_UNIT_NS / `PRM_CLK_PERIOD_NS)
`endif

/* File: prm_pkg.sv */
package prm_pkg;
  // Reference mux source codes.
  typedef enum logic [2:0] {
    PRM_SRC_REF1 = 3'h0,
    PRM_SRC_REF2 = 3'h1,
    PRM_SRC_REF3 = 3'h2,
    PRM_SRC_XPIN = 3'h3,
    PRM_SRC_XDRV = 3'h4
  } prm_src_t;
  // Monitor states, one-hot.
  typedef enum logic [2:0] {
    PRM_MON_BAD  = 3'b001,
    PRM_MON_QUAL = 3'b010,
    PRM_MON_OK   = 3'b100
  } prm_mon_t;
  // Input front-end settings handed to the analog receivers.
  typedef struct packed {
    logic [2:0] enable;
    logic [2:0] invert;
    logic [5:0] prescale;
    logic       xtal_halve;
    logic       doubler;
  } prm_in_cfg_t;
  // Feedback and output divider settings for the analog core.
  typedef struct packed {
    logic [41:0] fb_main;
    logic [31:0] fb_rem;
    logic [31:0] fb_den;
    logic [5:0]  fb_bp;
    logic [7:0]  vco_div;
  } prm_fb_cfg_t;
endpackage

/* File: prm_ref_src.sv */
`timescale 1ns/100ps
// ****************************************************************
// Reference clock sources and the selection pin.
// ****************************************************************
module prm_ref_src
#(
  parameter int HALF_NS = 50
)(
  input  wire logic [3:0] run,
  input  wire logic [3:0] pin,
  output logic      [2:0] ref_clk,
  output logic            xtal_clk,
  output logic      [3:0] gpio
);
  logic [3:0] ph;

  // A 10 MHz source sits inside the detector range with a divide by one.
  // A stopped source parks low, as a dead oscillator would.
  initial
  begin
    ph = 4'h0;
    forever
    begin
      #(HALF_NS);
      ph = ~ph & run;
    end
  end

  // The pin is a plain level that the bench sets.
  assign ref_clk  = ph[2:0];
  assign xtal_clk = ph[3];
  assign gpio     = pin;
endmodule // prm_ref_src

/* File: tb_top.sv */
`timescale 1ns/100ps
`include "prm_params.svh"
module tb_top
  import prm_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic [31:0] rdata;
  logic [2:0]  ref_clk;
  logic        xtal_clk;
  logic [3:0]  gpio;
  logic        pll_lock;
  logic        boot_done;
  logic        ring_en;
  logic        pll_en;
  prm_src_t    ref_sel;
  prm_in_cfg_t in_cfg;
  prm_fb_cfg_t fb_cfg;
  logic [3:0]  run;
  logic [3:0]  pin;
  logic [31:0] d;
  int          error_cnt;
  int          samples_checked;

  // ****************************************************************
  // Clock, instances and reporting.
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever
      #12.5 clk = ~clk;
  end

  prm_ref_ctrl #(.QBITS(10)) DUT (
    .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .REF_CLK(ref_clk), .XTAL_CLK(xtal_clk),
    .GPIO(gpio), .PLL_LOCK(pll_lock), .BOOT_DONE(boot_done),
    .RING_OSC_EN(ring_en), .PLL_EN(pll_en), .REF_SEL(ref_sel),
    .IN_CFG(in_cfg), .FB_CFG(fb_cfg)
  );

  prm_ref_src src (
    .run(run), .pin(pin), .ref_clk(ref_clk), .xtal_clk(xtal_clk), .gpio(gpio)
  );

  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Case inequality keeps an unknown from passing as a match.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // The strobe rises after one edge and drops after the next.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  // Read data stand from the cycle after the strobe and hold until the next read.
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    chk(pll_en, 1'b0);
    chk(ring_en, 1'b1);
    chk(fb_cfg.vco_div, 8'h06);
    chk(fb_cfg.fb_den, 32'h1);
    chk(fb_cfg.fb_bp, 6'h09);
    chk(in_cfg.enable, 3'h0);
    rd(8'h3C);
    chk(d, 32'h0);
    rd(`PRM_OFS_STATUS);
    chk(d[`PRM_ST_LOCK], 1'b0);
  endtask

  // Stopping the ring oscillator is refused until boot is done.
  task automatic t_boot();
    wr(`PRM_OFS_CTRL, 32'h2);
    cyc(3);
    chk(ring_en, 1'b1);
    boot_done <= 1'b1;
    pll_lock  <= 1'b1;
    cyc(6);
    wr(`PRM_OFS_CTRL, 32'h2);
    cyc(3);
    chk(ring_en, 1'b0);
    rd(`PRM_OFS_STATUS);
    chk(d[`PRM_ST_BOOT], 1'b1);
    chk(d[`PRM_ST_LOCK], 1'b1);
  endtask

  task automatic t_fb();
    wr(`PRM_OFS_FBM_LO, 32'h89AB_CDEF);
    wr(`PRM_OFS_FBM_HI, 32'hFFFF_FFFF);
    wr(`PRM_OFS_FB_REM, 32'h0000_0123);
    wr(`PRM_OFS_FB_DEN, 32'h0000_00ED);
    wr(`PRM_OFS_FB_BP, 32'h0000_000C);
    wr(`PRM_OFS_VCO_DIV, 32'h0000_0005);
    cyc(2);
    chk(fb_cfg.fb_main, 42'h3FF_89AB_CDEF);
    chk(fb_cfg.fb_rem, 32'h123);
    chk(fb_cfg.fb_den, 32'hED);
    chk(fb_cfg.fb_bp, 6'h0C);
    chk(fb_cfg.vco_div, 8'h05);
    rd(`PRM_OFS_FBM_LO);
    chk(d, 32'h89AB_CDEF);
    wr(`PRM_OFS_CTRL, 32'h3);
    cyc(2);
    chk(pll_en, 1'b1);
    wr(`PRM_OFS_CTRL, 32'h2);
    cyc(2);
    chk(pll_en, 1'b0);
  endtask

  task automatic t_incfg();
    wr(`PRM_OFS_INCFG, 32'h0000_0057);
    wr(`PRM_OFS_PRESC, 32'h0000_001B);
    wr(`PRM_OFS_CTRL, 32'h0000_000E);
    cyc(2);
    chk(in_cfg.enable, 3'h7);
    chk(in_cfg.invert, 3'h5);
    chk(in_cfg.prescale, 6'h1B);
    chk(in_cfg.xtal_halve, 1'b1);
    chk(in_cfg.doubler, 1'b1);
  endtask

  task automatic t_mux();
    wr(`PRM_OFS_CTRL, 32'h2);
    for (int i = 0; i < 5; i++)
    begin
      wr(`PRM_OFS_MUX, i);
      cyc(2);
      chk(ref_sel, i[2:0]);
      rd(`PRM_OFS_STATUS);
      chk(d[10:8], i[2:0]);
    end
  endtask

  // Pin two steers the mux; the other pins must not matter.
  task automatic t_pin();
    wr(`PRM_OFS_CTRL, 32'h92);
    wr(`PRM_OFS_MUX, 32'h31);
    cyc(8);
    chk(ref_sel, 3'h1);
    pin <= 4'hB;
    cyc(8);
    chk(ref_sel, 3'h1);
    pin <= 4'h4;
    cyc(8);
    chk(ref_sel, 3'h3);
    pin <= 4'h0;
  endtask

  task automatic t_mon();
    wr(`PRM_OFS_CTRL, 32'h22);
    wr(`PRM_OFS_MUX, 32'h20);
    wr(`PRM_OFS_INCFG, 32'h7);
    wr(`PRM_OFS_VALID_QUALIFY_TIME, 32'h0);
    run <= 4'h1;
    cyc(20);
    rd(`PRM_OFS_STATUS);
    chk(d[0], 1'b0);
    chk(ref_sel, 3'h2);
    cyc(50);
    rd(`PRM_OFS_STATUS);
    chk(d[0], 1'b1);
    chk(ref_sel, 3'h0);
    rd(`PRM_OFS_LATCH);
    chk(d[0], 1'b1);
    wr(`PRM_OFS_LATCH, 32'h1);
    rd(`PRM_OFS_LATCH);
    chk(d[0], 1'b0);
    run <= 4'h0;
    cyc(10);
    rd(`PRM_OFS_STATUS);
    chk(d[0], 1'b0);
    chk(ref_sel, 3'h2);
    rd(`PRM_OFS_LATCH);
    chk(d[0], 1'b1);
  endtask

  // Half-rate ticks and the doubler stretch the dead time to sixteen cycles.
  task automatic t_dbl();
    wr(`PRM_OFS_CTRL, 32'h2A);
    wr(`PRM_OFS_INCFG, 32'h107);
    run <= 4'h1;
    cyc(70);
    rd(`PRM_OFS_STATUS);
    chk(d[0], 1'b1);
    run <= 4'h0;
    cyc(10);
    rd(`PRM_OFS_STATUS);
    chk(d[0], 1'b1);
    cyc(14);
    rd(`PRM_OFS_STATUS);
    chk(d[0], 1'b0);
    run <= 4'h1;
    cyc(70);
    rd(`PRM_OFS_STATUS);
    chk(d[0], 1'b1);
    wr(`PRM_OFS_INCFG, 32'h106);
    cyc(2);
    rd(`PRM_OFS_STATUS);
    chk(d[0], 1'b0);
  endtask

  // ****************************************************************
  // Main sequence and watchdog.
  // ****************************************************************
  initial
  begin
    nrst      = 1'b0;
    addr      = 8'h00;
    wdata     = 32'h0;
    wr_s      = 1'b0;
    rd_s      = 1'b0;
    pll_lock  = 1'b0;
    boot_done = 1'b0;
    run       = 4'h0;
    pin       = 4'h0;
    cyc(10);
    nrst <= 1'b1;
    cyc(5);
    t_reset();
    t_boot();
    t_fb();
    t_incfg();
    t_mux();
    t_pin();
    t_mon();
    t_dbl();
    tally_and_finish();
  end

  // The whole run needs well under a thousand cycles.
  initial
  begin
    cyc(5000);
    error_cnt++;
    tally_and_finish();
  end
endmodule // tb_top
